// File: include/tmbc_consts.vh
// Constants for the second timer mode, gating and baud generation block
`ifndef TMBC_CONSTS_VH
`define TMBC_CONSTS_VH

// Register space address and reset value
`define TMBC_TMODE_ADDR 8'h89
`define TMBC_TMODE_RESET 8'h00
`define TMBC_RDATA_IDLE 8'h00
`define TMBC_COUNT_RESET 8'h00

// Field positions inside timer_mode_control
`define TMBC_GATE_BIT 7
`define TMBC_CSEL_BIT 6
`define TMBC_MODE_HI_BIT 5
`define TMBC_MODE_LO_BIT 4

// Mode encodings
`define TMBC_MODE_13BIT 2'h0
`define TMBC_MODE_16BIT 2'h1
`define TMBC_MODE_8RELOAD 2'h2
`define TMBC_MODE_HALT 2'h3

// Prescaler select encodings and divide ratios
`define TMBC_PSEL_DIV12 2'h0
`define TMBC_PSEL_DIV4 2'h1
`define TMBC_PSEL_DIV48 2'h2
`define TMBC_DIV12 6'h0C
`define TMBC_DIV4 6'h04
`define TMBC_DIV48 6'h30

// Counter widths and limits
`define TMBC_LOW13_MSB 4
`define TMBC_LOW13_MAX 5'h1F
`define TMBC_BYTE_MAX 8'hFF
`define TMBC_WORD_MAX 16'hFFFF

// Reference reload values for a 100.0 MHz core clock
`define TMBC_RELOAD_230400_DIRECT 8'h27
`define TMBC_RELOAD_115200_DIV4 8'h93

`endif

// File: core/tmbc_prescaler.v
// Core clock prescaler giving a one-cycle tick at /12, /4 or /48
`include "tmbc_consts.vh"

module tmbc_prescaler (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire [1:0] prescale_select_i,
    output wire tick_o
);

    reg [5:0] cnt_reg;
    reg [5:0] cnt_next;
    reg [5:0] div_w;

    // Encoding 11 is not defined; it falls back to /12
    always @* begin
        case (prescale_select_i)
            `TMBC_PSEL_DIV4: div_w = `TMBC_DIV4;
            `TMBC_PSEL_DIV48: div_w = `TMBC_DIV48;
            default: div_w = `TMBC_DIV12;
        endcase
    end

    assign tick_o = (cnt_reg >= (div_w - 6'h01));

    always @* begin
        if (tick_o) begin
            cnt_next = 6'h00;
        end else begin
            cnt_next = cnt_reg + 6'h01;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= 6'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule

// File: core/tmbc_timer_b.v
// Second timer: mode register, gating, clock selection, counter and baud output
//
// What this block does
// - Gate bit 0: count whenever run bit set
// - Gate bit 1: count needs run and gate pin
// - Mode field sits at bits 5 to 4
// - Mode 00 makes a 13-bit counter/timer
// - Reload 0x27 direct or 0x93 /4 baud
// - Prescaler /12, /4, /48; ignored when direct
`include "tmbc_consts.vh"

module tmbc_timer_b (
    input wire sys_clk_i,
    input wire arst_n_i,
    // Special-function register access
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    output wire [7:0] sfr_rdata_o,
    // Control bits held elsewhere
    input wire tmr_b_run_i,
    input wire tmr_b_direct_clock_i,
    input wire [1:0] prescale_select_i,
    // Counter load port
    input wire tmr_b_load_i,
    input wire [15:0] tmr_b_load_val_i,
    // Pins
    input wire ext_gate_input_b_i,
    input wire tmr_b_count_pin_i,
    // Status
    output wire [15:0] tmr_b_count_o,
    output wire tmr_b_overflow_o,
    output wire baud_clk_o,
    output wire [7:0] timer_mode_control_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    reg [7:0] tmode_reg;
    reg [7:0] tmode_next;
    reg [7:0] rdata_reg;
    reg [7:0] rdata_next;

    // Shared by the write and read paths so both decode the same address
    function addr_hit;
        input [7:0] addr;
        begin
            addr_hit = (addr == `TMBC_TMODE_ADDR);
        end
    endfunction

    always @* begin
        tmode_next = tmode_reg;
        if (sfr_wr_i && addr_hit(sfr_addr_i)) begin
            tmode_next = sfr_wdata_i;
        end
    end

    // Other addresses read as zero so a shared read bus can OR answers
    always @* begin
        rdata_next = `TMBC_RDATA_IDLE;
        if (sfr_rd_i && addr_hit(sfr_addr_i)) begin
            rdata_next = tmode_reg;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tmode_reg <= `TMBC_TMODE_RESET;
            rdata_reg <= `TMBC_RDATA_IDLE;
        end else begin
            tmode_reg <= tmode_next;
            rdata_reg <= rdata_next;
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign timer_mode_control_o = tmode_reg;

    wire tmr_b_gate_ctrl = tmode_reg[`TMBC_GATE_BIT];
    wire tmr_b_count_select = tmode_reg[`TMBC_CSEL_BIT];
    wire tmr_b_mode_hi = tmode_reg[`TMBC_MODE_HI_BIT];
    wire tmr_b_mode_lo = tmode_reg[`TMBC_MODE_LO_BIT];
    wire [1:0] mode_w = {tmr_b_mode_hi, tmr_b_mode_lo};

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    reg gate_meta_reg;
    reg gate_sync_reg;
    reg pin_meta_reg;
    reg pin_sync_reg;
    reg pin_prev_reg;

    // Edge history resets low: the pin settling high is never a fall
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gate_meta_reg <= 1'b0;
            gate_sync_reg <= 1'b0;
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            gate_meta_reg <= ext_gate_input_b_i;
            gate_sync_reg <= gate_meta_reg;
            pin_meta_reg <= tmr_b_count_pin_i;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Edge seen on synced copies only; pin low at one sampling edge is enough
    wire pin_fall_w = pin_prev_reg & ~pin_sync_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock selection and gating

    wire presc_tick_w;

    tmbc_prescaler u_prescaler (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .prescale_select_i(prescale_select_i),
        .tick_o(presc_tick_w)
    );

    // Direct clock overrides whatever the prescaler is set to
    wire timer_tick_w = tmr_b_direct_clock_i ? 1'b1 : presc_tick_w;

    wire src_tick_w = tmr_b_count_select ? pin_fall_w : timer_tick_w;

    // Gate pin only matters when the gate bit is set
    wire enable_w = tmr_b_run_i & (~tmr_b_gate_ctrl | gate_sync_reg);

    wire inc_w = enable_w & src_tick_w;

    ////////////////////////////////////////////////////////////////////////////
    // Counter

    reg [7:0] low_reg;
    reg [7:0] high_reg;
    reg [7:0] low_next;
    reg [7:0] high_next;
    reg ovf_next;
    reg ovf_reg;
    reg baud_next;
    reg baud_reg;

    // Mode 0 splits the low byte: five counting bits and three kept bits
    wire [4:0] low13_w = low_reg[`TMBC_LOW13_MSB:0];
    wire [2:0] low_keep_w = low_reg[7:`TMBC_LOW13_MSB + 1];
    wire [15:0] word_w = {high_reg, low_reg};

    always @* begin
        low_next = low_reg;
        high_next = high_reg;
        ovf_next = 1'b0;
        if (tmr_b_load_i) begin
            low_next = tmr_b_load_val_i[7:0];
            high_next = tmr_b_load_val_i[15:8];
        end else if (inc_w) begin
            case (mode_w)
                `TMBC_MODE_13BIT: begin
                    if (low13_w == `TMBC_LOW13_MAX) begin
                        low_next = {low_keep_w, 5'h00};
                        high_next = high_reg + 8'h01;
                        ovf_next = (high_reg == `TMBC_BYTE_MAX);
                    end else begin
                        low_next = {low_keep_w, low13_w + 5'h01};
                    end
                end
                `TMBC_MODE_16BIT: begin
                    {high_next, low_next} = word_w + 16'h0001;
                    ovf_next = (word_w == `TMBC_WORD_MAX);
                end
                `TMBC_MODE_8RELOAD: begin
                    // Baud source: overflow rate = tick / (256 - reload)
                    if (low_reg == `TMBC_BYTE_MAX) begin
                        low_next = high_reg;
                        ovf_next = 1'b1;
                    end else begin
                        low_next = low_reg + 8'h01;
                    end
                end
                default: begin
                    // Mode 3 holds the count
                    low_next = low_reg;
                end
            endcase
        end
    end

    // Two overflows per bit period, as the serial port expects
    always @* begin
        baud_next = baud_reg;
        if (ovf_next) begin
            baud_next = ~baud_reg;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_reg <= `TMBC_COUNT_RESET;
            high_reg <= `TMBC_COUNT_RESET;
            ovf_reg <= 1'b0;
            baud_reg <= 1'b0;
        end else begin
            low_reg <= low_next;
            high_reg <= high_next;
            ovf_reg <= ovf_next;
            baud_reg <= baud_next;
        end
    end

    assign tmr_b_count_o = word_w;
    assign tmr_b_overflow_o = ovf_reg;
    assign baud_clk_o = baud_reg;

endmodule

// File: sim/tmbc_timer_b_sva.sv
// Port-level assertions for the second timer block
module tmbc_timer_b_sva (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    input wire [7:0] sfr_rdata_o,
    input wire tmr_b_run_i,
    input wire tmr_b_direct_clock_i,
    input wire [1:0] prescale_select_i,
    input wire tmr_b_load_i,
    input wire ext_gate_input_b_i,
    input wire tmr_b_count_pin_i,
    input wire [15:0] tmr_b_count_o,
    input wire tmr_b_overflow_o,
    input wire baud_clk_o,
    input wire [7:0] timer_mode_control_o
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!arst_n_i);
wire [7:0] m = timer_mode_control_o;
wire [15:0] c = tmr_b_count_o;
wire go = tmr_b_run_i & ~tmr_b_load_i & ~m[6] & ~m[7];
wire dir = go & tmr_b_direct_clock_i;
////////////////////////////////////////////////////////////////////////////////
chk_direct_step: assert property (dir && m[5:4] == 2'h1 |=> c == $past(c) + 16'h1)
    else $error("direct count did not step");
chk_gate_block: assert property ((m[7] && !ext_gate_input_b_i && !tmr_b_load_i)[*4]
    |=> $stable(c)) else $error("gated count moved");
chk_mode0_carry: assert property (dir && m[5:4] == 2'h0 && c[4:0] == 5'h1F
    |=> c[4:0] == 5'h00 && c[15:8] == $past(c[15:8]) + 8'h1 && c[7:5] == $past(c[7:5]))
    else $error("thirteen bit carry wrong");
chk_reload_ovf: assert property (dir && m[5:4] == 2'h2 && c[7:0] == 8'hFF
    |=> c[7:0] == $past(c[15:8]) && tmr_b_overflow_o && baud_clk_o != $past(baud_clk_o))
    else $error("reload or baud toggle wrong");
// Select must sit still beforehand, the prescaler may restart on a change
chk_quarter_rate: assert property ((!tmr_b_direct_clock_i && go && m[5:4] == 2'h1
    && prescale_select_i == 2'h1)[*8] ##0 $past(prescale_select_i, 8) == 2'h1
    |=> c == $past(c, 8) + 16'h2) else $error("divide by four rate wrong");
chk_pin_quiet: assert property ((m[6] && tmr_b_count_pin_i && !tmr_b_load_i)[*8]
    |=> $stable(c)) else $error("count moved without pin edge");
chk_reg_write: assert property (sfr_wr_i && sfr_addr_i == 8'h89
    |=> m == $past(sfr_wdata_i)) else $error("mode write lost");
chk_reg_read: assert property (sfr_rd_i && sfr_addr_i == 8'h89
    |=> sfr_rdata_o == $past(m)) else $error("mode read wrong");
cov_reload: cover property (tmr_b_overflow_o);
cov_gated: cover property (m[7] && ext_gate_input_b_i && tmr_b_run_i);
cov_pin: cover property (m[6] && $fell(tmr_b_count_pin_i));
endmodule

bind tmbc_timer_b tmbc_timer_b_sva u_chk (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o),
    .tmr_b_run_i(tmr_b_run_i),
    .tmr_b_direct_clock_i(tmr_b_direct_clock_i),
    .prescale_select_i(prescale_select_i),
    .tmr_b_load_i(tmr_b_load_i),
    .ext_gate_input_b_i(ext_gate_input_b_i),
    .tmr_b_count_pin_i(tmr_b_count_pin_i),
    .tmr_b_count_o(tmr_b_count_o),
    .tmr_b_overflow_o(tmr_b_overflow_o),
    .baud_clk_o(baud_clk_o),
    .timer_mode_control_o(timer_mode_control_o)
);

// File: sim/tb_top.sv
// Self-checking bench for the second timer block
module tb_top;
timeunit 1ns;
timeprecision 1ps;
logic sys_clk_i, arst_n_i, sfr_wr_i, sfr_rd_i, tmr_b_run_i, tmr_b_direct_clock_i;
logic tmr_b_load_i, ext_gate_input_b_i, tmr_b_count_pin_i, tmr_b_overflow_o, baud_clk_o;
logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, timer_mode_control_o;
logic [1:0] prescale_select_i;
logic [15:0] tmr_b_load_val_i, tmr_b_count_o;
int fails = 0;
int compares = 0;
logic [15:0] base;
tmbc_timer_b DUT (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o),
    .tmr_b_run_i(tmr_b_run_i),
    .tmr_b_direct_clock_i(tmr_b_direct_clock_i),
    .prescale_select_i(prescale_select_i),
    .tmr_b_load_i(tmr_b_load_i),
    .tmr_b_load_val_i(tmr_b_load_val_i),
    .ext_gate_input_b_i(ext_gate_input_b_i),
    .tmr_b_count_pin_i(tmr_b_count_pin_i),
    .tmr_b_count_o(tmr_b_count_o),
    .tmr_b_overflow_o(tmr_b_overflow_o),
    .baud_clk_o(baud_clk_o),
    .timer_mode_control_o(timer_mode_control_o)
);
////////////////////////////////////////////////////////////////////////////////
task report_and_stop;
    if (fails == 0 && compares > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
task chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
        fails++;
        $display("BAD %s expected %h seen %h", n, e, g);
    end
endtask
task cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
endtask
task wr(input logic [7:0] a, d);
    @(posedge sys_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    sfr_wr_i <= 1'b0;
endtask
task rd(input logic [7:0] a, e);
    @(posedge sys_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    sfr_rd_i <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, sfr_rdata_o});
endtask
// Run, direct clock, prescale select, gate pin
task set(input logic [4:0] v);
    @(posedge sys_clk_i);
    {tmr_b_run_i, tmr_b_direct_clock_i, prescale_select_i, ext_gate_input_b_i} <= v;
endtask
task ld(input logic [15:0] v);
    @(posedge sys_clk_i);
    tmr_b_load_val_i <= v;
    tmr_b_load_i <= 1'b1;
    @(posedge sys_clk_i);
    tmr_b_load_i <= 1'b0;
endtask
// Settle s cycles so synchronisers and prescaler phase drop out, then measure
task span(input int s, n, input logic [15:0] d);
    logic [15:0] b;
    cyc(s);
    b = tmr_b_count_o;
    cyc(n);
    chk("count", b + d, tmr_b_count_o);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
end
initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    report_and_stop;
end
initial begin
    {arst_n_i, sfr_wr_i, sfr_rd_i, tmr_b_run_i, tmr_b_direct_clock_i, tmr_b_load_i} = '0;
    {ext_gate_input_b_i, tmr_b_count_pin_i} = 2'h1;
    {sfr_addr_i, sfr_wdata_i, prescale_select_i, tmr_b_load_val_i} = '0;
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rd(8'h89, 8'h00);
    wr(8'h89, 8'hA5);
    rd(8'h89, 8'hA5);
    wr(8'h8A, 8'hFF);
    rd(8'h8A, 8'h00);
    rd(8'h89, 8'hA5);
    wr(8'h89, 8'h10);
    set(5'h1C);
    span(2, 10, 16'h000A);
    wr(8'h89, 8'h90);
    span(4, 10, 16'h0000);
    set(5'h1D);
    span(4, 10, 16'h000A);
    wr(8'h89, 8'h10);
    set(5'h10);
    span(50, 48, 16'h0004);
    set(5'h12);
    span(50, 40, 16'h000A);
    set(5'h14);
    span(50, 96, 16'h0002);
    wr(8'h89, 8'h50);
    span(8, 8, 16'h0000);
    base = tmr_b_count_o;
    repeat (5) begin
        @(posedge sys_clk_i);
        tmr_b_count_pin_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        tmr_b_count_pin_i <= 1'b1;
        cyc(1);
    end
    cyc(2);
    chk("count", base + 16'h0005, tmr_b_count_o);
    span(0, 8, 16'h0000);
    wr(8'h89, 8'h00);
    set(5'h1C);
    ld(16'h12FE);
    cyc(2);
    chk("count", 16'h13E0, tmr_b_count_o);
    wr(8'h89, 8'h20);
    ld(16'h27FE);
    cyc(2);
    chk("count", 16'h2727, tmr_b_count_o);
    chk("ovf", 16'h0001, {15'h0000, tmr_b_overflow_o});
    // Reload 0x27 overflows every 256 - 0x27 = 217 ticks
    base = {15'h0000, baud_clk_o};
    cyc(216);
    chk("baud", base, {15'h0000, baud_clk_o});
    cyc(1);
    chk("baud", base ^ 16'h0001, {15'h0000, baud_clk_o});
    wr(8'h89, 8'h30);
    span(2, 10, 16'h0000);
    chk("mode", 16'h0030, {8'h00, timer_mode_control_o});
    report_and_stop;
end
endmodule
